// >>> fts_core.sv
// Purpose: flow-through burst sram core with back-to-back read and write
// Assumes: controller inputs synchronous to core_clk_in; sleep and order strap asynchronous
// Notes: array contents are not reset; LANES is 4 (36 bit) or 2 (18 bit)
`timescale 1ns/1ns
`include "fts_cfg.svh"

// Summary of operation
// - clock qualifier high: edge ignored, operation state held; sleep sequencing and write buffer drain still run
// - load edge, all selects active, write enable high: read starts, address captured
// - read word appears in the cycle after the address edge, no extra stage
// - read data driven only while output drive enable is low, asynchronously
// - a new operation is accepted on the edge right after a read
// - inactive select on a load edge deselects and tristates at once
// - internal burst counter serves up to four accesses per loaded address
// - order strap low: linear add; high: interleaved xor of start bits
// - only the two low address bits step and wrap; higher bits held
// - advance edge steps the counter, ignores selects and write enable
// - read or write choice latched at load, kept for the whole burst
// - load edge, all selects active, write enable low: write starts, lane selects latched
// - write detected: data and parity lines released whatever the drive enable
// - write data taken on the next edge; a new operation may load then too
// - only lanes with active-low select written, each with its parity bit
// - sleep is asynchronous, two cycles to enter and leave, array kept
// - access pending when sleep begins may be lost
// - after reset the device is deselected with lines high impedance
module fts_core #(
  parameter int LANES = `FTS_LANES,
  parameter int AW = (LANES == `FTS_LANES_MAX) ? `FTS_ADDR_W_WIDE : `FTS_ADDR_W_NARROW
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clock_qualifier_n_in,
  input wire logic chip_select_first_n_in,
  input wire logic chip_select_second_in,
  input wire logic chip_select_third_n_in,
  input wire logic advance_or_load_in,
  input wire logic write_enable_n_in,
  input wire logic [LANES-1:0] byte_lane_select_n_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [8*LANES-1:0] data_in,
  input wire logic [LANES-1:0] parity_lines_in,
  input wire logic output_drive_enable_n_in,
  input wire logic burst_order_in,
  input wire logic sleep_request_in,
  output logic [8*LANES-1:0] data_out,
  output logic [LANES-1:0] parity_lines_out,
  output logic data_oe_out,
  output logic sleep_active_out
);
  logic [`FTS_WORD_W-1:0] mem [0:(1<<AW)-1];

  fts_pkg::fts_op_e op_q;
  fts_pkg::fts_op_e op_d;
  fts_pkg::fts_addr_t base_q;
  fts_pkg::fts_addr_t base_d;
  fts_pkg::fts_burst_t start_q;
  fts_pkg::fts_burst_t start_d;
  fts_pkg::fts_burst_t cnt_q;
  fts_pkg::fts_burst_t cnt_d;
  fts_pkg::fts_mask_t sel_n_q;
  fts_pkg::fts_mask_t sel_n_d;
  fts_pkg::fts_addr_t cur_addr;
  fts_pkg::fts_addr_t nxt_addr;
  fts_pkg::fts_word_t rd_q;
  fts_pkg::fts_word_t rd_word;
  fts_pkg::fts_word_t in_word;
  fts_pkg::fts_mask_t lane_sel_n;
  fts_pkg::fts_slp_e slp_q;
  logic [1:0] slp_cnt_q;
  logic [1:0] async_sync;
  logic sleep_sync;
  logic order_sync;
  logic asleep;
  logic rd_active_q;
  logic cs_all;
  logic go;
  logic push_valid;
  logic push_ready;
  logic drain_valid;
  logic drain_ready;
  fts_pkg::fts_wr_word_s push_data;
  fts_pkg::fts_wr_word_s drain_data;
  logic [`FTS_DATA_W_MAX-1:0] out_data_full;
  fts_pkg::fts_mask_t out_par_full;

  // next two low address bits of a burst step
  function automatic fts_pkg::fts_burst_t burst_lsb(input fts_pkg::fts_burst_t start,
                                                     input fts_pkg::fts_burst_t cnt,
                                                     input logic interleave);
    burst_lsb = interleave ? (start ^ cnt) : fts_pkg::fts_burst_t'(start + cnt);
  endfunction

  // overlay the selected lanes of a written word on an older word
  function automatic fts_pkg::fts_word_t lane_merge(input fts_pkg::fts_word_t old_w,
                                                     input fts_pkg::fts_word_t new_w,
                                                     input fts_pkg::fts_mask_t sel_n);
    fts_pkg::fts_word_t r;
    r = old_w;
    for (int i = 0; i < `FTS_LANES_MAX; i++) begin
      if (!sel_n[i]) begin
        r[i*`FTS_LANE_W +: `FTS_LANE_W] = new_w[i*`FTS_LANE_W +: `FTS_LANE_W];
      end
    end
    lane_merge = r;
  endfunction

  // sleep request and order strap come from pins
  fts_sync #(
    .W(2)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .d_in({sleep_request_in, burst_order_in}),
    .q_out(async_sync)
  );
  assign sleep_sync = async_sync[1];
  assign order_sync = async_sync[0];

  assign cs_all = ~chip_select_first_n_in & chip_select_second_in & ~chip_select_third_n_in;
  assign asleep = (slp_q == fts_pkg::FTS_SL_ASLEEP) || (slp_q == fts_pkg::FTS_SL_EXIT);

  // a full write buffer stalls the pipeline like a held qualifier
  assign go = ~clock_qualifier_n_in & ~asleep & (push_ready | (op_q != fts_pkg::FTS_OP_WRITE));

  // unused lanes of a two-lane part read as unselected
  assign lane_sel_n = ~fts_pkg::fts_mask_t'(~byte_lane_select_n_in);

  always_comb begin
    in_word = '0;
    for (int i = 0; i < LANES; i++) begin
      in_word[i*`FTS_LANE_W +: `FTS_LANE_W] = {parity_lines_in[i], data_in[i*8 +: 8]};
    end
  end

  assign cur_addr = {base_q[`FTS_ADDR_W_MAX-1:`FTS_BURST_W], burst_lsb(start_q, cnt_q, order_sync)};
  assign nxt_addr = {base_d[`FTS_ADDR_W_MAX-1:`FTS_BURST_W], burst_lsb(start_d, cnt_d, order_sync)};

  // command decode for the next edge
  always_comb begin
    op_d = op_q;
    base_d = base_q;
    start_d = start_q;
    cnt_d = cnt_q;
    sel_n_d = sel_n_q;
    if (!advance_or_load_in) begin
      if (cs_all) begin
        op_d = write_enable_n_in ? fts_pkg::FTS_OP_READ : fts_pkg::FTS_OP_WRITE;
        base_d = fts_pkg::fts_addr_t'(addr_in);
        start_d = addr_in[`FTS_BURST_W-1:0];
        cnt_d = `FTS_BURST_ZERO;
        sel_n_d = lane_sel_n;
      end else begin
        op_d = fts_pkg::FTS_OP_IDLE;
      end
    end else if (op_q != fts_pkg::FTS_OP_IDLE) begin
      // selects and write enable are not looked at here
      cnt_d = fts_pkg::fts_burst_t'(cnt_q + `FTS_BURST_STEP);
      sel_n_d = lane_sel_n;
    end
  end

  // operation pipeline; every operation may follow any other directly
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_q <= fts_pkg::FTS_OP_IDLE;
      base_q <= '0;
      start_q <= `FTS_BURST_ZERO;
      cnt_q <= `FTS_BURST_ZERO;
      sel_n_q <= '1;
    end else if (asleep) begin
      op_q <= fts_pkg::FTS_OP_IDLE;
    end else if (go) begin
      op_q <= op_d;
      base_q <= base_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
      sel_n_q <= sel_n_d;
    end
  end

  // write data arrives on the edge after its command
  assign push_valid = ~clock_qualifier_n_in & ~asleep & (op_q == fts_pkg::FTS_OP_WRITE);
  assign push_data = '{addr: cur_addr, lane_sel_n: sel_n_q, word: in_word};

  fts_buf u_wbuf (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(push_data),
    .out_valid_out(drain_valid),
    .out_ready_in(drain_ready),
    .out_data_out(drain_data)
  );

  // the array is frozen while asleep, so buffered words wait
  assign drain_ready = ~asleep;

  always_ff @(posedge core_clk_in) begin
    if (drain_valid && drain_ready) begin
      mem[drain_data.addr[AW-1:0]] <= lane_merge(mem[drain_data.addr[AW-1:0]], drain_data.word,
                                                 drain_data.lane_sel_n);
    end
  end

  // forwarding covers a word still in the buffer or arriving on this edge
  always_comb begin
    rd_word = mem[nxt_addr[AW-1:0]];
    if (drain_valid && (drain_data.addr == nxt_addr)) begin
      rd_word = lane_merge(rd_word, drain_data.word, drain_data.lane_sel_n);
    end
    if (push_valid && push_ready && (push_data.addr == nxt_addr)) begin
      rd_word = lane_merge(rd_word, push_data.word, push_data.lane_sel_n);
    end
  end

  // array read is taken on the address edge itself
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q <= '0;
      rd_active_q <= 1'b0;
    end else if (asleep) begin
      rd_active_q <= 1'b0;
    end else if (go) begin
      rd_active_q <= (op_d == fts_pkg::FTS_OP_READ);
      if (op_d == fts_pkg::FTS_OP_READ) begin
        rd_q <= rd_word;
      end
    end
  end

  always_comb begin
    out_data_full = '0;
    out_par_full = '0;
    for (int i = 0; i < `FTS_LANES_MAX; i++) begin
      out_data_full[i*8 +: 8] = rd_q[i*`FTS_LANE_W +: 8];
      out_par_full[i] = rd_q[i*`FTS_LANE_W + 8];
    end
  end

  assign data_out = out_data_full[8*LANES-1:0];
  assign parity_lines_out = out_par_full[LANES-1:0];
  // enable not sampled, so the drivers follow it within the cycle
  assign data_oe_out = rd_active_q & ~output_drive_enable_n_in & ~asleep;

  // sleep sequencing runs regardless of the clock qualifier
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      slp_q <= fts_pkg::FTS_SL_AWAKE;
      slp_cnt_q <= '0;
    end else begin
      unique case (slp_q)
        fts_pkg::FTS_SL_AWAKE: begin
          if (sleep_sync) begin
            slp_q <= fts_pkg::FTS_SL_ENTER;
            slp_cnt_q <= `FTS_SLEEP_CNT_ONE;
          end
        end
        fts_pkg::FTS_SL_ENTER: begin
          if (!sleep_sync) begin
            slp_q <= fts_pkg::FTS_SL_AWAKE;
          end else if (slp_cnt_q == `FTS_SLEEP_ENTER_CYC) begin
            slp_q <= fts_pkg::FTS_SL_ASLEEP;
          end else begin
            slp_cnt_q <= 2'(slp_cnt_q + `FTS_SLEEP_CNT_ONE);
          end
        end
        fts_pkg::FTS_SL_ASLEEP: begin
          if (!sleep_sync) begin
            slp_q <= fts_pkg::FTS_SL_EXIT;
            slp_cnt_q <= `FTS_SLEEP_CNT_ONE;
          end
        end
        fts_pkg::FTS_SL_EXIT: begin
          if (sleep_sync) begin
            slp_q <= fts_pkg::FTS_SL_ASLEEP;
          end else if (slp_cnt_q == `FTS_SLEEP_EXIT_CYC) begin
            slp_q <= fts_pkg::FTS_SL_AWAKE;
          end else begin
            slp_cnt_q <= 2'(slp_cnt_q + `FTS_SLEEP_CNT_ONE);
          end
        end
      endcase
    end
  end

  assign sleep_active_out = asleep;
endmodule // fts_core

// >>> fts_cfg.svh
// Purpose: constants for the flow-through burst sram core
// Assumes: one 125 MHz clock, 8 ns period
// Notes: definitions only
`ifndef FTS_CFG_SVH
`define FTS_CFG_SVH

`define FTS_LANES 4
`define FTS_LANES_MAX 4
`define FTS_LANE_W 9
`define FTS_WORD_W 36
`define FTS_DATA_W_MAX 32
`define FTS_ADDR_W_MAX 20
`define FTS_ADDR_W_WIDE 19
`define FTS_ADDR_W_NARROW 20
`define FTS_BURST_W 2
`define FTS_BURST_ZERO 2'h0
`define FTS_BURST_STEP 2'h1
`define FTS_CLK_PERIOD_NS 8
`define FTS_SLEEP_ENTER_TCYC 2
`define FTS_SLEEP_EXIT_TCYC 2
`define FTS_SLEEP_ENTER_CYC 2'(`FTS_SLEEP_ENTER_TCYC)
`define FTS_SLEEP_EXIT_CYC 2'(`FTS_SLEEP_EXIT_TCYC)
`define FTS_SLEEP_CNT_ONE 2'h1
`define FTS_BUF_PTR_ONE 1'h1
`define FTS_BUF_CNT_FULL 2'h2
`define FTS_BUF_CNT_ONE 2'h1
`define FTS_BUF_CNT_ZERO 2'h0

`endif

// >>> fts_pkg.sv
// Purpose: shared types of the flow-through burst sram core
// Assumes: fts_cfg.svh on the include path
// Notes: words are held at the widest lane count
`include "fts_cfg.svh"

package fts_pkg;
  typedef logic [`FTS_WORD_W-1:0] fts_word_t;
  typedef logic [`FTS_LANES_MAX-1:0] fts_mask_t;
  typedef logic [`FTS_ADDR_W_MAX-1:0] fts_addr_t;
  typedef logic [`FTS_BURST_W-1:0] fts_burst_t;

  typedef enum logic [1:0] {
    FTS_OP_IDLE,
    FTS_OP_READ,
    FTS_OP_WRITE
  } fts_op_e;

  typedef enum logic [1:0] {
    FTS_SL_AWAKE,
    FTS_SL_ENTER,
    FTS_SL_ASLEEP,
    FTS_SL_EXIT
  } fts_slp_e;

  typedef struct packed {
    fts_addr_t addr;
    fts_mask_t lane_sel_n;
    fts_word_t word;
  } fts_wr_word_s;
endpackage

// >>> fts_sync.sv
// Purpose: three-stage synchroniser for asynchronous levels
// Assumes: inputs are static for at least two clocks to count
// Notes: output follows only once stages two and three agree
`timescale 1ns/1ns

module fts_sync #(
  parameter int W = 2
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit: a one-cycle glitch past stage two never reaches the output
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // fts_sync

// >>> fts_buf.sv
// Purpose: two-entry write buffer with valid and ready on both sides
// Assumes: one clock
// Notes: in_ready drops only when both entries are held
`timescale 1ns/1ns
`include "fts_cfg.svh"

module fts_buf (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input fts_pkg::fts_wr_word_s in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output fts_pkg::fts_wr_word_s out_data_out
);
  fts_pkg::fts_wr_word_s ent_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_out = (cnt_q != `FTS_BUF_CNT_FULL);
  assign out_valid_out = (cnt_q != `FTS_BUF_CNT_ZERO);
  assign out_data_out = ent_q[rd_ptr_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      ent_q[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= `FTS_BUF_CNT_ZERO;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q ^ `FTS_BUF_PTR_ONE;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q ^ `FTS_BUF_PTR_ONE;
      end
      if (push && !pop) begin
        cnt_q <= 2'(cnt_q + `FTS_BUF_CNT_ONE);
      end else if (pop && !push) begin
        cnt_q <= 2'(cnt_q - `FTS_BUF_CNT_ONE);
      end
    end
  end
endmodule // fts_buf

// >>> fts_core_properties.sv
// Purpose: port-level checks on the sram core
// Assumes: one clock, reset active high and asynchronous
// Notes: bound to every fts_core instance
`timescale 1ns/1ns

module fts_core_properties #(
  parameter int LANES = 4
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clock_qualifier_n_in,
  input wire logic chip_select_first_n_in,
  input wire logic chip_select_second_in,
  input wire logic chip_select_third_n_in,
  input wire logic advance_or_load_in,
  input wire logic write_enable_n_in,
  input wire logic output_drive_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic [8*LANES-1:0] data_out,
  input wire logic data_oe_out,
  input wire logic sleep_active_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire sel_on = !chip_select_first_n_in && chip_select_second_in && !chip_select_third_n_in;
  // loads while asleep are ignored, so they are left out
  sequence s_load;
    !clock_qualifier_n_in && !advance_or_load_in && !sleep_request_in && !sleep_active_out;
  endsequence
  sequence s_rd_load;
    s_load ##0 sel_on && write_enable_n_in;
  endsequence
  sequence s_wr_load;
    s_load ##0 sel_on && !write_enable_n_in;
  endsequence
  sequence s_desel;
    s_load ##0 !sel_on;
  endsequence
  sequence s_slp_hold;
    sleep_request_in [*8];
  endsequence
  sequence s_wake_hold;
    !sleep_request_in [*8];
  endsequence

  a_stall_holds_data: assert property (clock_qualifier_n_in |=> $stable(data_out))
    else $error("read data moved on an ignored edge");
  a_read_drives_bus: assert property (s_rd_load ##1 !output_drive_enable_n_in |-> data_oe_out)
    else $error("read not driven in the following cycle");
  a_back_to_back: assert property (s_rd_load ##1 (s_wr_load or s_desel) |=> !data_oe_out)
    else $error("operation after a read not taken at once");
  a_write_releases: assert property (s_wr_load |=> !data_oe_out)
    else $error("lines driven after a write load");
  a_deselect_off: assert property (s_desel |=> !data_oe_out)
    else $error("lines driven after a deselect");
  a_oe_gates_bus: assert property (output_drive_enable_n_in |-> !data_oe_out)
    else $error("lines driven with output enable high");
  a_advance_keeps_read: assert property (!clock_qualifier_n_in && advance_or_load_in && data_oe_out
    && !sleep_request_in ##1 !output_drive_enable_n_in |-> data_oe_out)
    else $error("read burst lost its type on advance");
  a_sleep_enters: assert property ($rose(sleep_request_in) ##0 s_slp_hold |-> sleep_active_out)
    else $error("sleep not entered in time");
  a_sleep_leaves: assert property ($fell(sleep_request_in) ##0 s_wake_hold |-> !sleep_active_out)
    else $error("sleep not left in time");
  a_asleep_quiet: assert property (sleep_active_out |-> !data_oe_out)
    else $error("lines driven while asleep");
  a_reset_quiet: assert property ($fell(rst_in) |-> !data_oe_out && !sleep_active_out)
    else $error("not idle after reset");
endmodule // fts_core_properties

bind fts_core fts_core_properties #(.LANES(LANES)) i_props (
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .clock_qualifier_n_in(clock_qualifier_n_in),
  .chip_select_first_n_in(chip_select_first_n_in),
  .chip_select_second_in(chip_select_second_in),
  .chip_select_third_n_in(chip_select_third_n_in),
  .advance_or_load_in(advance_or_load_in),
  .write_enable_n_in(write_enable_n_in),
  .output_drive_enable_n_in(output_drive_enable_n_in),
  .sleep_request_in(sleep_request_in),
  .data_out(data_out),
  .data_oe_out(data_oe_out),
  .sleep_active_out(sleep_active_out)
);

// >>> fts_ctrl_model.sv
// Purpose: behavioural memory controller facing the sram core
// Assumes: one command per qualified clock, issued by the bench
// Notes: data lines show the inverse of the last word when not writing
`timescale 1ns/1ns

module fts_ctrl_model (
  input wire logic core_clk_in,
  output logic qual_n_out,
  output logic cs1_n_out,
  output logic cs2_out,
  output logic cs3_n_out,
  output logic adv_out,
  output logic we_n_out,
  output logic [3:0] lane_n_out,
  output logic [18:0] addr_out,
  output logic [35:0] wd_out,
  output logic oe_n_out,
  output logic order_out,
  output logic slp_out
);
  initial begin
    {qual_n_out, cs2_out, adv_out, oe_n_out, order_out, slp_out} = 6'h00;
    {cs1_n_out, cs3_n_out, we_n_out} = 3'h7;
    lane_n_out = 4'hf;
    addr_out = 19'h0;
    wd_out = 36'h0;
  end

  // codes: 0 read, 1 write, 2/5/6 deselect by select one/two/three, 3 advance, 4 stall
  task automatic cmd(input int k, input logic [18:0] a, input logic [3:0] l, input logic [35:0] w, input bit v);
    @(posedge core_clk_in);
    qual_n_out <= (k == 4);
    if (k != 4) begin
      adv_out <= (k == 3);
      cs1_n_out <= (k == 2 || k == 3);
      cs2_out <= (k != 5);
      cs3_n_out <= (k == 6);
      we_n_out <= (k != 1);
      addr_out <= a;
      lane_n_out <= l;
      wd_out <= v ? w : ~wd_out;
    end
  endtask

  // callers deselect first and hold selects off after release
  task automatic slp(input logic v);
    @(posedge core_clk_in);
    slp_out <= v;
  endtask

  // async pins, changed away from the clock edge
  task automatic pins(input logic oe, input logic ord);
    oe_n_out = oe;
    order_out = ord;
  endtask
endmodule // fts_ctrl_model

// >>> flow_through_burst_sram_core_bench.sv
// Purpose: self-checking bench for the sram core
// Assumes: four lanes, 8 ns clock
// Notes: expected words worked out from lane masks and burst order
`timescale 1ns/1ns

module flow_through_burst_sram_core_bench;
  localparam int RD = 0, WR = 1, DS = 2, ADV = 3, STL = 4;
  localparam logic [18:0] A = 19'h00010;
  localparam logic [35:0] W1 = 36'h123456789;
  localparam logic [35:0] W2 = 36'hedcba9876;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic q, c1, c2, c3, adv, we, oe, ord, slp, data_oe_out, sleep_active_out;
  logic [3:0] ln, parity_lines_out;
  logic [18:0] ad;
  logic [35:0] wd, kept;
  logic [31:0] data_out;
  wire [35:0] rdw = {parity_lines_out, data_out};
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #4 core_clk_in = ~core_clk_in;

  fts_ctrl_model i_ctrl (.core_clk_in(core_clk_in), .qual_n_out(q), .cs1_n_out(c1), .cs2_out(c2),
    .cs3_n_out(c3), .adv_out(adv), .we_n_out(we), .lane_n_out(ln), .addr_out(ad), .wd_out(wd),
    .oe_n_out(oe), .order_out(ord), .slp_out(slp));

  fts_core #(.LANES(4)) i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .clock_qualifier_n_in(q),
    .chip_select_first_n_in(c1), .chip_select_second_in(c2), .chip_select_third_n_in(c3),
    .advance_or_load_in(adv), .write_enable_n_in(we), .byte_lane_select_n_in(ln), .addr_in(ad),
    .data_in(wd[31:0]), .parity_lines_in(wd[35:32]), .output_drive_enable_n_in(oe),
    .burst_order_in(ord), .sleep_request_in(slp), .data_out(data_out),
    .parity_lines_out(parity_lines_out), .data_oe_out(data_oe_out), .sleep_active_out(sleep_active_out));

  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_word({35'h0, got}, {35'h0, exp});
  endtask

  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n, input logic [3:0] m);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (!m[i]) begin
        merge[8*i+:8] = n[8*i+:8];
        merge[32+i] = n[32+i];
      end
    end
  endfunction

  function automatic logic [35:0] pat(input logic [1:0] j);
    return 36'ha5a5a5a50 + 36'(j);
  endfunction

  task automatic wr1(input logic [18:0] a, input logic [3:0] l, input logic [35:0] w);
    i_ctrl.cmd(WR, a, l, 36'h0, 0);
    i_ctrl.cmd(DS, a, 4'hf, w, 1);
  endtask

  // read then load a deselect of kind k on the very next edge
  task automatic rd1(input logic [18:0] a, input logic [35:0] exp, input int k);
    i_ctrl.cmd(RD, a, 4'hf, 36'h0, 0);
    i_ctrl.cmd(k, a, 4'hf, 36'h0, 0);
    @(negedge core_clk_in) chk_word(rdw, exp);
    i_ctrl.cmd(DS, a, 4'hf, 36'h0, 0);
    @(negedge core_clk_in) chk_flag(data_oe_out, 1'b0);
  endtask

  task automatic t_reset();
    @(negedge core_clk_in) chk_flag(data_oe_out, 1'b0);
    chk_flag(sleep_active_out, 1'b0);
  endtask

  task automatic t_rw();
    i_ctrl.cmd(WR, A, 4'h0, 36'h0, 0);
    i_ctrl.cmd(RD, A, 4'hf, W1, 1);
    @(negedge core_clk_in) chk_flag(data_oe_out, 1'b0);
    i_ctrl.cmd(DS, A, 4'hf, 36'h0, 0);
    @(negedge core_clk_in) chk_word(rdw, W1);
    i_ctrl.cmd(DS, A, 4'hf, 36'h0, 0);
    @(negedge core_clk_in) chk_flag(data_oe_out, 1'b0);
  endtask

  task automatic t_lanes();
    wr1(A, 4'ha, W2);
    kept = merge(W1, W2, 4'ha);
    rd1(A, kept, 5);
    // all lanes unselected: a write abort leaves the word alone
    wr1(A, 4'hf, W1);
    rd1(A, kept, 2);
  endtask

  task automatic t_burst(input logic o);
    logic [18:0] b;
    logic [1:0] c, x, j;
    b = 19'h12340;
    i_ctrl.pins(1'b0, o);
    wr1(b + 19'h4, 4'h0, W1);
    repeat (6) i_ctrl.cmd(DS, b, 4'hf, 36'h0, 0);
    i_ctrl.cmd(WR, b + 19'h3, 4'h0, 36'h0, 0);
    for (int i = 0; i < 3; i++) begin
      i_ctrl.cmd(ADV, 19'h0, 4'h0, pat(2'(i)), 1);
    end
    i_ctrl.cmd(DS, b, 4'hf, pat(2'h3), 1);
    for (int i = 0; i < 4; i++) begin
      x = o ? (2'h3 ^ 2'(i)) : (2'h3 + 2'(i));
      rd1(b | 19'(x), pat(2'(i)), 2);
    end
    rd1(b + 19'h4, W1, 6);
    // read burst from start one with a stall, then a fifth step wraps
    i_ctrl.cmd(RD, b + 19'h1, 4'hf, 36'h0, 0);
    for (int i = 0; i < 6; i++) begin
      i_ctrl.cmd(i == 2 ? STL : (i == 5 ? DS : ADV), 19'h0, 4'hf, 36'h0, 0);
      c = 2'(i < 3 ? i : i - 1);
      x = o ? (2'h1 ^ c) : (2'h1 + c);
      j = o ? (x ^ 2'h3) : (x + 2'h1);
      @(negedge core_clk_in) chk_word(rdw, pat(j));
    end
  endtask

  task automatic t_oe();
    i_ctrl.pins(1'b1, 1'b0);
    i_ctrl.cmd(RD, A, 4'hf, 36'h0, 0);
    i_ctrl.cmd(DS, A, 4'hf, 36'h0, 0);
    @(negedge core_clk_in) chk_flag(data_oe_out, 1'b0);
    i_ctrl.pins(1'b0, 1'b0);
    #1 chk_flag(data_oe_out, 1'b1);
    chk_word(rdw, kept);
    i_ctrl.cmd(DS, A, 4'hf, 36'h0, 0);
  endtask

  task automatic t_sleep();
    i_ctrl.slp(1'b1);
    repeat (10) @(posedge core_clk_in);
    @(negedge core_clk_in) chk_flag(sleep_active_out, 1'b1);
    chk_flag(data_oe_out, 1'b0);
    i_ctrl.slp(1'b0);
    repeat (10) i_ctrl.cmd(DS, A, 4'hf, 36'h0, 0);
    @(negedge core_clk_in) chk_flag(sleep_active_out, 1'b0);
    rd1(A, kept, 2);
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // whole run needs about 120 cycles
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_rw();
    t_lanes();
    t_burst(1'b0);
    t_burst(1'b1);
    t_oe();
    t_sleep();
    final_report();
  end
endmodule // flow_through_burst_sram_core_bench
